/* File: indicator_pkg.sv */
package indicator_pkg;

  // system clock and flash timing
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned FAST_PERIOD_MS = 1000;
  localparam int unsigned SLOW_PERIOD_MS = 2000;
  localparam int unsigned GRACE_S = 30;
  // half period of the fast flash, in cycles
  localparam int unsigned FAST_HALF_CYC = (FAST_PERIOD_MS / 2) * (CLK_HZ / 1000);
  // slow flash is the fast phase divided by two
  localparam int unsigned SLOW_RATIO = SLOW_PERIOD_MS / FAST_PERIOD_MS;
  // grace interval counted in fast half periods
  localparam int unsigned GRACE_HALVES = GRACE_S * 1000 / (FAST_PERIOD_MS / 2);
  localparam int unsigned DIV_W = 25;
  localparam int unsigned GRACE_W = 7;

  // bicolour led drive: bit 1 red, bit 0 green
  localparam logic [1:0] LED_OFF = 2'h0;
  localparam logic [1:0] LED_GREEN = 2'h1;
  localparam logic [1:0] LED_RED = 2'h2;

  // segment patterns, bit order g..a, active high
  localparam logic [6:0] SEG_DASH = 7'h40;
  localparam logic [6:0] SEG_BLANK = 7'h00;

  // condition inputs from internal status logic
  typedef struct packed {
    logic restarting;
    logic init_wait;
    logic initializing;
    logic io_downloading;
    logic hw_critical;
    logic watchdog_timeout;
    logic bus_recoverable;
    logic running_ok;
    logic orig_active;
    logic orig_all_up;
    logic orig_comm_err;
    logic orig_target_missing;
    logic fb_active;
    logic fb_all_up;
    logic fb_comm_err;
    logic fb_master_missing;
    logic fb_io_absent;
    logic prog_halt_err;
    logic prog_local_err;
    logic prog_running;
    logic debug_mode;
    logic fatal;
    logic validated;
    logic sig_confirmed;
    logic [7:0] sig_low;
  } status_in_t;

  // front panel outputs
  typedef struct packed {
    logic [1:0] bus_status_led;
    logic [1:0] originator_network_led;
    logic [1:0] fieldbus_safety_led;
    logic prog_err_led;
    logic run_led;
    logic debug_led;
    logic valid_led;
    logic [6:0] seg_hi;
    logic [6:0] seg_lo;
  } panel_t;

  // indicator state machine for power-up grace
  typedef enum logic [0:0] {
    PH_GRACE = 1'b0,
    PH_NORMAL = 1'b1
  } phase_t;

  // whole module state
  typedef struct packed {
    logic [DIV_W-1:0] div;
    logic fast_ph;
    logic slow_ph;
    logic [GRACE_W-1:0] grace_cnt;
    phase_t phase;
    status_in_t st;
    panel_t panel;
  } ind_state_t;

endpackage

/* File: panel_viewer.sv */
`timescale 1ns/1ns
module panel_viewer
  import indicator_pkg::*;
(
  // panel as the operator sees it
  input wire panel_t panel,
  // digits read off the display
  output logic [3:0] hi_val,
  output logic [3:0] lo_val,
  output logic hi_ok,
  output logic lo_ok
);
  // plain hex font, g..a active high
  localparam logic [6:0] FONT [16] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D,
    7'h07, 7'h7F, 7'h6F, 7'h77, 7'h7C, 7'h39, 7'h5E, 7'h79, 7'h71};
  ////////////////////////////////////////////////////////////////////////////////
  // glyph to nibble; a dash or blank reads as no digit
  function automatic logic [4:0] read_glyph(input logic [6:0] seg);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < 16; i++) begin
      if (seg === FONT[i]) r = {1'b1, 4'(i)};
    end
    return r;
  endfunction
  // an operator reads both digits at once
  always_comb begin
    {hi_ok, hi_val} = read_glyph(panel.seg_hi);
    {lo_ok, lo_val} = read_glyph(panel.seg_lo);
  end
endmodule

/* File: safety_cpu_status_indicators.sv */
`timescale 1ns/1ns
module safety_cpu_status_indicators
  import indicator_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // internal status conditions, same clock domain
  input wire status_in_t status_in,
  // front panel drive
  output panel_t panel
);

  ind_state_t cur_ff;
  ind_state_t nxt_ff;

  ////////////////////////////////////////////////////////////////////////////
  // hex digit to segment pattern
  function automatic logic [6:0] hex_seg(input logic [3:0] v);
    logic [6:0] s;
    s = 7'h00;
    unique case (v)
      4'h0: s = 7'h3F;
      4'h1: s = 7'h06;
      4'h2: s = 7'h5B;
      4'h3: s = 7'h4F;
      4'h4: s = 7'h66;
      4'h5: s = 7'h6D;
      4'h6: s = 7'h7D;
      4'h7: s = 7'h07;
      4'h8: s = 7'h7F;
      4'h9: s = 7'h6F;
      4'hA: s = 7'h77;
      4'hB: s = 7'h7C;
      4'hC: s = 7'h39;
      4'hD: s = 7'h5E;
      4'hE: s = 7'h79;
      4'hF: s = 7'h71;
    endcase
    return s;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic half_tick;
    logic in_grace;
    status_in_t s;
    half_tick = 1'b0;
    in_grace = 1'b0;
    nxt_ff = cur_ff;
    // inputs registered once so panel decode sees stable values
    nxt_ff.st = status_in;
    s = cur_ff.st;

    // single divider feeds every flash phase, keeping them aligned
    if (cur_ff.div == DIV_W'(FAST_HALF_CYC - 1)) begin
      nxt_ff.div = '0;
      half_tick = 1'b1;
    end else begin
      nxt_ff.div = cur_ff.div + DIV_W'(1);
    end
    if (half_tick) begin
      nxt_ff.fast_ph = ~cur_ff.fast_ph;
      // slow phase toggles on every other fast toggle: 2 s period
      if (cur_ff.fast_ph) begin
        nxt_ff.slow_ph = ~cur_ff.slow_ph;
      end
    end

    // power-up grace window, counted in half periods
    unique case (cur_ff.phase)
      PH_GRACE: begin
        in_grace = 1'b1;
        if (half_tick) begin
          if (cur_ff.grace_cnt == GRACE_W'(GRACE_HALVES - 1)) begin
            nxt_ff.phase = PH_NORMAL;
          end else begin
            nxt_ff.grace_cnt = cur_ff.grace_cnt + GRACE_W'(1);
          end
        end
      end
      PH_NORMAL: begin
        in_grace = 1'b0;
      end
    endcase

    // bus status: priority chain from most severe down
    if (s.hw_critical || s.watchdog_timeout) begin
      nxt_ff.panel.bus_status_led = LED_RED;
    end else if (s.bus_recoverable) begin
      nxt_ff.panel.bus_status_led = cur_ff.fast_ph ? LED_RED : LED_OFF;
    end else if (s.restarting || s.init_wait) begin
      nxt_ff.panel.bus_status_led = LED_OFF;
    end else if (s.initializing || s.io_downloading) begin
      nxt_ff.panel.bus_status_led = cur_ff.slow_ph ? LED_GREEN : LED_OFF;
    end else if (s.running_ok) begin
      nxt_ff.panel.bus_status_led = LED_GREEN;
    end else begin
      nxt_ff.panel.bus_status_led = LED_OFF;
    end

    // originator network; missing target in grace still flashes red
    if (!s.orig_active) begin
      nxt_ff.panel.originator_network_led = LED_OFF;
    end else if (s.orig_comm_err || (s.orig_target_missing && in_grace)) begin
      nxt_ff.panel.originator_network_led = cur_ff.fast_ph ? LED_RED : LED_OFF;
    end else if (s.orig_all_up) begin
      nxt_ff.panel.originator_network_led = LED_GREEN;
    end else begin
      nxt_ff.panel.originator_network_led = cur_ff.fast_ph ? LED_GREEN : LED_OFF;
    end

    // fieldbus safety; absent io during grace masks the missing-master error
    if (!s.fb_active) begin
      nxt_ff.panel.fieldbus_safety_led = LED_OFF;
    end else if (s.fb_comm_err ||
                 (s.fb_master_missing && !(in_grace && s.fb_io_absent))) begin
      nxt_ff.panel.fieldbus_safety_led = cur_ff.fast_ph ? LED_RED : LED_OFF;
    end else if (s.fb_all_up && !s.fb_master_missing) begin
      nxt_ff.panel.fieldbus_safety_led = LED_GREEN;
    end else begin
      nxt_ff.panel.fieldbus_safety_led = cur_ff.fast_ph ? LED_GREEN : LED_OFF;
    end

    // program error: halting error outranks local error
    if (s.prog_halt_err) begin
      nxt_ff.panel.prog_err_led = 1'b1;
    end else if (s.prog_local_err) begin
      nxt_ff.panel.prog_err_led = cur_ff.fast_ph;
    end else begin
      nxt_ff.panel.prog_err_led = 1'b0;
    end

    // run indicator; fatal fault forces dark
    if (s.fatal) begin
      nxt_ff.panel.run_led = 1'b0;
    end else if (s.initializing) begin
      nxt_ff.panel.run_led = cur_ff.fast_ph;
    end else begin
      nxt_ff.panel.run_led = s.prog_running;
    end

    nxt_ff.panel.debug_led = s.debug_mode && !s.fatal;
    nxt_ff.panel.valid_led = s.validated && !s.fatal;

    // display: blanked on the dark half while originator links establish
    if (s.orig_active && !s.orig_all_up && !cur_ff.fast_ph) begin
      nxt_ff.panel.seg_hi = SEG_BLANK;
      nxt_ff.panel.seg_lo = SEG_BLANK;
    end else if (!s.sig_confirmed) begin
      nxt_ff.panel.seg_hi = SEG_DASH;
      nxt_ff.panel.seg_lo = SEG_DASH;
    end else begin
      nxt_ff.panel.seg_hi = hex_seg(s.sig_low[7:4]);
      nxt_ff.panel.seg_lo = hex_seg(s.sig_low[3:0]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign panel = cur_ff.panel;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic fast_edge;
  assign fast_edge = (cur_ff.div == DIV_W'(FAST_HALF_CYC - 1));

  chk_bus_critical_red: assert property (@(posedge clk) disable iff (!reset_n)
    (cur_ff.st.hw_critical || cur_ff.st.watchdog_timeout) |=> panel.bus_status_led == LED_RED)
    else $error("bus led not red on critical error");

  chk_bus_normal_green: assert property (@(posedge clk) disable iff (!reset_n)
    (cur_ff.st.running_ok && !cur_ff.st.hw_critical && !cur_ff.st.watchdog_timeout &&
     !cur_ff.st.bus_recoverable && !cur_ff.st.restarting && !cur_ff.st.init_wait &&
     !cur_ff.st.initializing && !cur_ff.st.io_downloading)
    |=> panel.bus_status_led == LED_GREEN)
    else $error("bus led not green in normal run");

  chk_bus_restart_dark: assert property (@(posedge clk) disable iff (!reset_n)
    (cur_ff.st.restarting && !cur_ff.st.hw_critical && !cur_ff.st.watchdog_timeout &&
     !cur_ff.st.bus_recoverable) |=> panel.bus_status_led == LED_OFF)
    else $error("bus led lit while restarting");

  chk_fast_phase_toggle: assert property (@(posedge clk) disable iff (!reset_n)
    fast_edge |=> cur_ff.fast_ph != $past(cur_ff.fast_ph))
    else $error("fast phase did not toggle on divider wrap");

  chk_fast_phase_hold: assert property (@(posedge clk) disable iff (!reset_n)
    !fast_edge |=> $stable(cur_ff.fast_ph))
    else $error("fast phase moved between divider wraps");

  chk_slow_from_fast: assert property (@(posedge clk) disable iff (!reset_n)
    (fast_edge && !cur_ff.fast_ph) |=> $stable(cur_ff.slow_ph))
    else $error("slow phase toggled at wrong fast edge");

  chk_prog_halt_red: assert property (@(posedge clk) disable iff (!reset_n)
    cur_ff.st.prog_halt_err |=> panel.prog_err_led)
    else $error("program error led not lit on halting error");

  chk_debug_fatal_off: assert property (@(posedge clk) disable iff (!reset_n)
    cur_ff.st.fatal |=> !panel.debug_led && !panel.run_led && !panel.valid_led)
    else $error("led lit after fatal fault");

  chk_orig_idle_dark: assert property (@(posedge clk) disable iff (!reset_n)
    !cur_ff.st.orig_active |=> panel.originator_network_led == LED_OFF)
    else $error("originator led lit while idle");

  chk_fb_grace_mask: assert property (@(posedge clk) disable iff (!reset_n)
    (cur_ff.phase == PH_GRACE && cur_ff.st.fb_active && !cur_ff.st.fb_comm_err &&
     cur_ff.st.fb_io_absent) |=> panel.fieldbus_safety_led != LED_RED)
    else $error("fieldbus led red during grace with io absent");

  chk_sig_dash: assert property (@(posedge clk) disable iff (!reset_n)
    (!cur_ff.st.sig_confirmed && !cur_ff.st.orig_active) |=>
    panel.seg_hi == SEG_DASH && panel.seg_lo == SEG_DASH)
    else $error("display not dashed with unconfirmed signature");

  // bus led flashes follow the phase held when the status was sampled
  chk_bus_recov_flash: assert property (@(posedge clk) disable iff (!reset_n)
    (cur_ff.st.bus_recoverable && !cur_ff.st.hw_critical && !cur_ff.st.watchdog_timeout)
    |=> panel.bus_status_led == ($past(cur_ff.fast_ph) ? LED_RED : LED_OFF))
    else $error("bus led not flashing red on recoverable error");

  chk_bus_init_slow: assert property (@(posedge clk) disable iff (!reset_n)
    ((cur_ff.st.initializing || cur_ff.st.io_downloading) && !cur_ff.st.hw_critical &&
     !cur_ff.st.watchdog_timeout && !cur_ff.st.bus_recoverable && !cur_ff.st.restarting &&
     !cur_ff.st.init_wait)
    |=> panel.bus_status_led == ($past(cur_ff.slow_ph) ? LED_GREEN : LED_OFF))
    else $error("bus led not slow flashing green during init");

  // originator led; a missing target in grace flashes red instead of counting
  chk_orig_up_green: assert property (@(posedge clk) disable iff (!reset_n)
    (cur_ff.st.orig_active && cur_ff.st.orig_all_up && !cur_ff.st.orig_comm_err &&
     !cur_ff.st.orig_target_missing) |=> panel.originator_network_led == LED_GREEN)
    else $error("originator led not green with links up");

  chk_orig_connect_flash: assert property (@(posedge clk) disable iff (!reset_n)
    (cur_ff.st.orig_active && !cur_ff.st.orig_all_up && !cur_ff.st.orig_comm_err &&
     !cur_ff.st.orig_target_missing)
    |=> panel.originator_network_led == ($past(cur_ff.fast_ph) ? LED_GREEN : LED_OFF))
    else $error("originator led not flashing green while connecting");

  chk_orig_err_red: assert property (@(posedge clk) disable iff (!reset_n)
    (cur_ff.st.orig_active && cur_ff.st.orig_comm_err)
    |=> panel.originator_network_led == ($past(cur_ff.fast_ph) ? LED_RED : LED_OFF))
    else $error("originator led not flashing red on comm error");

  chk_orig_grace_red: assert property (@(posedge clk) disable iff (!reset_n)
    (cur_ff.phase == PH_GRACE && cur_ff.st.orig_active && cur_ff.st.orig_target_missing)
    |=> panel.originator_network_led == ($past(cur_ff.fast_ph) ? LED_RED : LED_OFF))
    else $error("originator led not flashing red for missing target in grace");

  // fieldbus led
  chk_fb_up_green: assert property (@(posedge clk) disable iff (!reset_n)
    (cur_ff.st.fb_active && cur_ff.st.fb_all_up && !cur_ff.st.fb_comm_err &&
     !cur_ff.st.fb_master_missing) |=> panel.fieldbus_safety_led == LED_GREEN)
    else $error("fieldbus led not green with all masters up");

  chk_fb_err_red: assert property (@(posedge clk) disable iff (!reset_n)
    (cur_ff.st.fb_active && cur_ff.st.fb_comm_err)
    |=> panel.fieldbus_safety_led == ($past(cur_ff.fast_ph) ? LED_RED : LED_OFF))
    else $error("fieldbus led not flashing red on comm error");

  chk_fb_idle_dark: assert property (@(posedge clk) disable iff (!reset_n)
    !cur_ff.st.fb_active |=> panel.fieldbus_safety_led == LED_OFF)
    else $error("fieldbus led lit while not executed");

  chk_fb_grace_green: assert property (@(posedge clk) disable iff (!reset_n)
    (cur_ff.phase == PH_GRACE && cur_ff.st.fb_active && !cur_ff.st.fb_comm_err &&
     cur_ff.st.fb_io_absent && cur_ff.st.fb_master_missing)
    |=> panel.fieldbus_safety_led == ($past(cur_ff.fast_ph) ? LED_GREEN : LED_OFF))
    else $error("fieldbus led not flashing green in grace with io absent");

  // program error and run leds
  chk_prog_local_flash: assert property (@(posedge clk) disable iff (!reset_n)
    (!cur_ff.st.prog_halt_err && cur_ff.st.prog_local_err)
    |=> panel.prog_err_led == $past(cur_ff.fast_ph))
    else $error("program error led not flashing on local error");

  chk_prog_clear_dark: assert property (@(posedge clk) disable iff (!reset_n)
    (!cur_ff.st.prog_halt_err && !cur_ff.st.prog_local_err) |=> !panel.prog_err_led)
    else $error("program error led lit without error");

  chk_run_init_flash: assert property (@(posedge clk) disable iff (!reset_n)
    (!cur_ff.st.fatal && cur_ff.st.initializing) |=> panel.run_led == $past(cur_ff.fast_ph))
    else $error("run led not flashing during init");

  chk_run_prog_on: assert property (@(posedge clk) disable iff (!reset_n)
    (!cur_ff.st.fatal && !cur_ff.st.initializing)
    |=> panel.run_led == $past(cur_ff.st.prog_running))
    else $error("run led does not follow program execution");

  // mode leds and display
  chk_debug_mode_on: assert property (@(posedge clk) disable iff (!reset_n)
    (cur_ff.st.debug_mode && !cur_ff.st.fatal) |=> panel.debug_led)
    else $error("debug led dark in debug mode");

  chk_valid_stored_on: assert property (@(posedge clk) disable iff (!reset_n)
    (cur_ff.st.validated && !cur_ff.st.fatal) |=> panel.valid_led)
    else $error("valid led dark with validated data stored");

  chk_seg_connect_blank: assert property (@(posedge clk) disable iff (!reset_n)
    (cur_ff.st.orig_active && !cur_ff.st.orig_all_up && !cur_ff.fast_ph) |=>
    panel.seg_hi == SEG_BLANK && panel.seg_lo == SEG_BLANK)
    else $error("display not blanked on dark half while connecting");

  chk_seg_steady_digits: assert property (@(posedge clk) disable iff (!reset_n)
    (cur_ff.st.sig_confirmed && (cur_ff.st.orig_all_up || !cur_ff.st.orig_active)) |=>
    panel.seg_lo != SEG_BLANK && panel.seg_lo != SEG_DASH && panel.seg_hi != SEG_BLANK)
    else $error("display not showing digits once links are steady");

  // timebase; a runaway divider would stretch every flash at once
  chk_div_in_range: assert property (@(posedge clk) disable iff (!reset_n)
    cur_ff.div <= DIV_W'(FAST_HALF_CYC - 1))
    else $error("flash divider beyond its half period");

  chk_grace_no_reopen: assert property (@(posedge clk) disable iff (!reset_n)
    cur_ff.phase == PH_NORMAL |=> cur_ff.phase == PH_NORMAL)
    else $error("grace window reopened after it closed");

  cov_bus_recover_flash: cover property (@(posedge clk) disable iff (!reset_n)
    panel.bus_status_led == LED_RED ##1 panel.bus_status_led == LED_OFF);
  cov_grace_end: cover property (@(posedge clk) disable iff (!reset_n)
    cur_ff.phase == PH_GRACE ##1 cur_ff.phase == PH_NORMAL);
  cov_orig_up: cover property (@(posedge clk) disable iff (!reset_n)
    panel.originator_network_led == LED_GREEN && panel.seg_lo != SEG_BLANK);
  cov_fb_grace_mask: cover property (@(posedge clk) disable iff (!reset_n)
    cur_ff.phase == PH_GRACE && cur_ff.st.fb_master_missing && cur_ff.st.fb_io_absent);
  cov_seg_blank: cover property (@(posedge clk) disable iff (!reset_n)
    panel.seg_hi == SEG_BLANK && panel.seg_lo == SEG_BLANK);

endmodule

/* File: safety_cpu_status_indicators_tb.sv */
`timescale 1ns/1ns
module safety_cpu_status_indicators_tb
  import indicator_pkg::*;
;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  status_in_t s = '0;
  panel_t panel;
  logic [3:0] hi_val;
  logic [3:0] lo_val;
  logic hi_ok;
  logic lo_ok;
  int fails = 0;
  int cmp_count = 0;
  ////////////////////////////////////////////////////////////////////////////////
  // 50 MHz clock
  always #10 clk = ~clk;
  safety_cpu_status_indicators i_dut (.clk(clk), .reset_n(reset_n), .status_in(s),
    .panel(panel));
  panel_viewer i_view (.panel(panel), .hi_val(hi_val), .lo_val(lo_val), .hi_ok(hi_ok),
    .lo_ok(lo_ok));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s exp %0h seen %0h", name, exp, seen);
    end
  endtask
  // the whole run stays in the first low flash phase and in the grace window,
  // so a flashing indicator reads dark here
  task automatic set(input status_in_t v);
    @(negedge clk);
    s = v;
    repeat (3) @(negedge clk);
  endtask
  // each flashing case but perr local, fb grace and fb miss keeps a steady lower-ranked
  // condition set, so that a missing rule shows a lit led where the dark flash half is expected
  task automatic t_bus();
    status_in_t v;
    v = '0;
    v.running_ok = 1'b1;
    set(v);
    check("bus ok", 8'(panel.bus_status_led), 8'(LED_GREEN));
    v.initializing = 1'b1;
    set(v);
    check("bus init", 8'(panel.bus_status_led), 8'(LED_OFF));
    v.initializing = 1'b0;
    v.io_downloading = 1'b1;
    set(v);
    check("bus dl", 8'(panel.bus_status_led), 8'(LED_OFF));
    v.hw_critical = 1'b1;
    v.bus_recoverable = 1'b1;
    set(v);
    check("bus crit", 8'(panel.bus_status_led), 8'(LED_RED));
    v.hw_critical = 1'b0;
    v.watchdog_timeout = 1'b1;
    set(v);
    check("bus wdt", 8'(panel.bus_status_led), 8'(LED_RED));
    v.watchdog_timeout = 1'b0;
    v.io_downloading = 1'b0;
    set(v);
    check("bus recov", 8'(panel.bus_status_led), 8'(LED_OFF));
    v = '0;
    v.running_ok = 1'b1;
    v.restarting = 1'b1;
    set(v);
    check("bus restart", 8'(panel.bus_status_led), 8'(LED_OFF));
    v.restarting = 1'b0;
    v.init_wait = 1'b1;
    set(v);
    check("bus wait", 8'(panel.bus_status_led), 8'(LED_OFF));
  endtask
  task automatic t_links();
    status_in_t v;
    v = '0;
    v.orig_all_up = 1'b1;
    v.fb_all_up = 1'b1;
    set(v);
    check("orig idle", 8'(panel.originator_network_led), 8'(LED_OFF));
    check("fb idle", 8'(panel.fieldbus_safety_led), 8'(LED_OFF));
    v.orig_active = 1'b1;
    v.fb_active = 1'b1;
    set(v);
    check("orig up", 8'(panel.originator_network_led), 8'(LED_GREEN));
    check("fb up", 8'(panel.fieldbus_safety_led), 8'(LED_GREEN));
    v.orig_target_missing = 1'b1;
    v.fb_master_missing = 1'b1;
    v.fb_io_absent = 1'b1;
    set(v);
    check("orig grace", 8'(panel.originator_network_led), 8'(LED_OFF));
    // masked master loss flashes green, dark in this half period
    check("fb grace", 8'(panel.fieldbus_safety_led), 8'(LED_OFF));
    v.orig_target_missing = 1'b0;
    v.orig_comm_err = 1'b1;
    v.fb_io_absent = 1'b0;
    set(v);
    check("orig err", 8'(panel.originator_network_led), 8'(LED_OFF));
    check("fb miss", 8'(panel.fieldbus_safety_led), 8'(LED_OFF));
    v.fb_master_missing = 1'b0;
    v.fb_comm_err = 1'b1;
    set(v);
    check("fb err", 8'(panel.fieldbus_safety_led), 8'(LED_OFF));
  endtask
  task automatic t_modes();
    status_in_t v;
    v = '0;
    v.prog_halt_err = 1'b1;
    v.prog_local_err = 1'b1;
    v.prog_running = 1'b1;
    v.debug_mode = 1'b1;
    v.validated = 1'b1;
    set(v);
    check("perr halt", 8'(panel.prog_err_led), 8'h01);
    check("run on", 8'(panel.run_led), 8'h01);
    check("dbg on", 8'(panel.debug_led), 8'h01);
    check("valid on", 8'(panel.valid_led), 8'h01);
    v.prog_halt_err = 1'b0;
    v.initializing = 1'b1;
    set(v);
    check("perr local", 8'(panel.prog_err_led), 8'h00);
    check("run init", 8'(panel.run_led), 8'h00);
    v.initializing = 1'b0;
    v.fatal = 1'b1;
    set(v);
    check("run fatal", 8'(panel.run_led), 8'h00);
    check("dbg fatal", 8'(panel.debug_led), 8'h00);
    check("valid fatal", 8'(panel.valid_led), 8'h00);
  endtask
  task automatic t_display();
    status_in_t v;
    v = '0;
    v.sig_low = 8'hA5;
    set(v);
    check("seg dash", {1'b0, panel.seg_hi}, {1'b0, SEG_DASH});
    check("seg dash lo", {1'b0, panel.seg_lo}, {1'b0, SEG_DASH});
    v.sig_confirmed = 1'b1;
    for (int i = 0; i < 16; i++) begin
      v.sig_low = {4'(i), 4'(15 - i)};
      set(v);
      check("seg digits", {hi_ok, lo_ok, 6'h00}, 8'hC0);
      check("seg value", {hi_val, lo_val}, v.sig_low);
    end
    v.orig_active = 1'b1;
    set(v);
    check("seg connecting", {1'b0, panel.seg_hi}, {1'b0, SEG_BLANK});
    v.orig_all_up = 1'b1;
    set(v);
    check("seg steady", {hi_val, lo_val}, v.sig_low);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // main sequence; reset for six cycles, released off the sampling edge
  initial begin
    repeat (6) @(posedge clk);
    @(negedge clk);
    reset_n = 1'b1;
    check("panel reset", 8'(panel.bus_status_led), 8'h00);
    t_bus();
    t_links();
    t_modes();
    t_display();
    final_report();
  end
  // a hang outlasts the roughly 140 cycles the tests need many times over
  initial begin
    #(20 * 5000);
    fails++;
    final_report();
  end
endmodule
